// *** logic/afe_path_consts.svh ***
// constants for the receive-path mode configuration block
`ifndef AFE_PATH_CONSTS_SVH
`define AFE_PATH_CONSTS_SVH

// register port widths
`define REG_ADDR_W          8
`define REG_DATA_W          16

// register offsets on the host register port
`define OFF_INPUT_CFG       8'h14
`define OFF_SLOT_A_INT_CTRL 8'h42
`define OFF_SLOT_A_PATH     8'h43
`define OFF_SLOT_B_INT_CTRL 8'h44
`define OFF_SLOT_B_PATH     8'h45
`define OFF_BUF_MODE_EN     8'h58
`define OFF_SLOT_A_DATA     8'h70
`define OFF_SLOT_B_DATA     8'h71

// reset values
`define RST_INPUT_CFG       16'h0555
`define RST_INT_CTRL        16'h1C00
`define RST_PATH_WORD       16'hADA5
`define RST_BUF_MODE_EN     16'h0000
`define RST_DATA            16'h0000

// integrator control fields
`define INT_SETUP_HI        15
`define INT_SETUP_LO        10
`define INT_GAIN_HI         9
`define INT_GAIN_LO         8
`define INT_AS_BUF_BIT      7
`define GAIN_CODE_07        2'h2

// global buffer enable field
`define BUF_GLOBAL_EN_BIT   7

// input configuration fields
`define PD_SEL_B_HI         11
`define PD_SEL_B_LO         8
`define PD_SEL_A_HI         7
`define PD_SEL_A_LO         4
`define LED_SEL_B_HI        3
`define LED_SEL_B_LO        2
`define LED_SEL_A_HI        1
`define LED_SEL_A_LO        0

// path connection codes
`define PATH_NORMAL         16'hADA5
`define PATH_BPF_BYPASS     16'hAE65
`define PATH_FULL_BYPASS    16'hB065

// dc sampling timing
`define CLK_PERIOD_NS       20
`define SAMPLE_SPACING_NS   1000
`define SAMPLE_SPACING_CYC  ((`SAMPLE_SPACING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DC_CHANNELS         4

`endif

// *** logic/afe_path_pkg.sv ***
// types shared by the receive-path mode configuration block
package afe_path_pkg;

   // decoded arrangement of one slot's receive path
   typedef struct packed {
      logic       bpf_bypass;
      logic       int_bypass;
      logic       int_buffer;
      logic       gain_07;
      logic       dc_mode;
      logic       pulse_connect;
      logic [5:0] int_setup;
      logic [3:0] pd_sel;
   } path_cfg_t;

   // dc channel sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_RUN  = 2'b10
   } seq_state_t;

endpackage : afe_path_pkg

// *** logic/slot_path_decoder.sv ***
// decoder from one slot's register fields to its path arrangement
`timescale 1ns/1ps
`default_nettype none
`include "afe_path_consts.svh"

module slot_path_decoder (
   input  wire logic [15:0]           int_ctrl,
   input  wire logic [15:0]           path_word,
   input  wire logic                  global_en,
   input  wire logic [1:0]            led_sel,
   input  wire logic [3:0]            pd_sel,
   output var  afe_path_pkg::path_cfg_t cfg
);

   // compare a path word against one connection code
   function automatic logic path_is(input logic [15:0] w,
                                    input logic [15:0] code);
      path_is = (w == code);
   endfunction : path_is

   logic bpf_off;
   logic int_off;
   logic buf_on;

   // path word selects bypass of filter and integrator
   assign bpf_off = path_is(path_word, `PATH_BPF_BYPASS)
                  | path_is(path_word, `PATH_FULL_BYPASS);
   assign int_off = path_is(path_word, `PATH_FULL_BYPASS);
   // buffer conversion needs the slot bit and the global bit
   assign buf_on  = int_ctrl[`INT_AS_BUF_BIT] & global_en;

   // assemble the slot arrangement
   assign cfg.bpf_bypass    = bpf_off;
   assign cfg.int_bypass    = int_off;
   assign cfg.int_buffer    = buf_on & ~int_off;
   assign cfg.gain_07       = (int_ctrl[`INT_GAIN_HI:`INT_GAIN_LO]
                               == `GAIN_CODE_07);
   assign cfg.dc_mode       = bpf_off;
   assign cfg.pulse_connect = (led_sel == 2'h0);
   assign cfg.int_setup     = int_ctrl[`INT_SETUP_HI:`INT_SETUP_LO];
   assign cfg.pd_sel        = pd_sel;

endmodule : slot_path_decoder
`default_nettype wire

// *** logic/dc_channel_sequencer.sv ***
// sequencer that strobes the converter channels one after another
`timescale 1ns/1ps
`default_nettype none
`include "afe_path_consts.svh"

module dc_channel_sequencer #(
   parameter int CHANNELS = `DC_CHANNELS,
   parameter int SPACING  = `SAMPLE_SPACING_CYC
) (
   input  wire logic                        clk,
   input  wire logic                        srst,
   input  wire logic                        ce,
   input  wire logic                        go,
   output var  logic                        strobe,
   output var  logic [$clog2(CHANNELS)-1:0] chan
);

   localparam int CW = $clog2(CHANNELS);
   localparam int GW = $clog2(SPACING);
   localparam logic [GW-1:0] GAP_LAST = GW'(SPACING - 1);
   localparam logic [CW-1:0] CH_LAST  = CW'(CHANNELS - 1);

   afe_path_pkg::seq_state_t state_reg;
   afe_path_pkg::seq_state_t state_next;
   logic [GW-1:0]            gap_reg;
   logic [GW-1:0]            gap_next;
   logic [CW-1:0]            chan_reg;
   logic [CW-1:0]            chan_next;
   logic                     strobe_reg;
   logic                     strobe_next;

   // one strobe per channel, spaced by the sample spacing
   always_comb begin
      state_next  = state_reg;
      gap_next    = gap_reg;
      chan_next   = chan_reg;
      strobe_next = 1'b0;
      case (state_reg)
         afe_path_pkg::SEQ_IDLE: begin
            if (go) begin
               state_next  = afe_path_pkg::SEQ_RUN;
               gap_next    = GAP_LAST;
               chan_next   = '0;
               strobe_next = 1'b1;
            end
         end
         afe_path_pkg::SEQ_RUN: begin
            if (gap_reg != '0) begin
               gap_next = gap_reg - 1'b1;
            end else if (chan_reg == CH_LAST) begin
               state_next = afe_path_pkg::SEQ_IDLE;
            end else begin
               chan_next   = chan_reg + 1'b1;
               gap_next    = GAP_LAST;
               strobe_next = 1'b1;
            end
         end
         default: begin
            state_next = afe_path_pkg::SEQ_IDLE;
         end
      endcase
   end

   // state registers, frozen while ce is low
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg  <= afe_path_pkg::SEQ_IDLE;
         gap_reg    <= '0;
         chan_reg   <= '0;
         strobe_reg <= 1'b0;
      end else if (ce) begin
         state_reg  <= state_next;
         gap_reg    <= gap_next;
         chan_reg   <= chan_next;
         strobe_reg <= strobe_next;
      end
   end

   assign strobe = strobe_reg;
   assign chan   = chan_reg;

   // helper: enabled cycles since the last strobe
   logic [GW:0] since_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         since_reg <= '0;
      end else if (ce) begin
         since_reg <= strobe_reg ? (GW+1)'(1) : since_reg + 1'b1;
      end
   end

   a_strobe_spacing: assert property (@(posedge clk) disable iff (srst)
      strobe_reg && chan_reg != '0 |-> since_reg == (GW+1)'(SPACING))
      else $error("channel strobes not one sample spacing apart");

   a_chan_order: assert property (@(posedge clk) disable iff (srst)
      ce && strobe_next && chan_next != '0
      |=> chan_reg == $past(chan_reg) + 1'b1)
      else $error("channels not strobed in order");

endmodule : dc_channel_sequencer
`default_nettype wire

// *** logic/afe_path_mode_config.sv ***
// receive-path mode configuration for two slots with dc sampling control
`timescale 1ns/1ps
`default_nettype none
`include "afe_path_consts.svh"
// Operation
// - gain code 10 gives 0.7, else 1.0
// - slot buffer bit turns integrator into buffer
// - global enable gates both slots' buffer selection
// - ADA5 normal path, AE65 bypasses filter only
// - B065 bypasses filter and integrator both
// - zero input select disconnects photodiode inputs
// - pulse connect gates inputs with LED timing
// - zero LED select enters pulse connect mode
// - slots configured independently, alternate measurements
// - zero offsets pass raw dc converter code
// - results via fifo or per-slot data registers
// - dc mode samples four channels, 1 us apart

module afe_path_mode_config #(
   parameter int CHANNELS = `DC_CHANNELS,
   parameter int SPACING  = `SAMPLE_SPACING_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          srst,
   input  wire logic                          ce,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   input  wire logic [`REG_ADDR_W-1:0]        reg_addr,
   input  wire logic [`REG_DATA_W-1:0]        reg_wdata,
   output var  logic [`REG_DATA_W-1:0]        reg_rdata,
   output var  logic                          reg_rvalid,
   input  wire logic                          slot_start,
   input  wire logic                          slot_is_b,
   input  wire logic                          sample_start,
   input  wire logic                          led_pulse,
   input  wire logic                          adc_valid,
   input  wire logic [15:0]                   adc_code,
   input  wire logic [15:0]                   adc_offset,
   output var  afe_path_pkg::path_cfg_t       slot_cfg,
   output var  logic                          active_is_b,
   output var  logic [3:0]                    pd_connect,
   output var  logic                          led_fire_en,
   output var  logic                          adc_strobe,
   output var  logic [$clog2(CHANNELS)-1:0]   adc_channel,
   output var  logic                          fifo_valid,
   output var  logic [15:0]                   fifo_data
);

   // host-visible registers
   logic [15:0] input_config_reg;
   logic [15:0] slot_a_integrator_control_reg;
   logic [15:0] slot_a_path_connection_reg;
   logic [15:0] slot_b_integrator_control_reg;
   logic [15:0] slot_b_path_connection_reg;
   logic [15:0] buffer_mode_enable_reg;
   logic [15:0] slot_a_data_reg;
   logic [15:0] slot_b_data_reg;

   // address match, used by both the write and the read decode
   function automatic logic addr_hit(input logic [`REG_ADDR_W-1:0] a,
                                     input logic [`REG_ADDR_W-1:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   logic we_input;
   logic we_a_ctrl;
   logic we_a_path;
   logic we_b_ctrl;
   logic we_b_path;
   logic we_buf_en;
   logic wr_go;

   // write strobes per register
   assign wr_go     = ce & reg_wr;
   assign we_input  = wr_go & addr_hit(reg_addr, `OFF_INPUT_CFG);
   assign we_a_ctrl = wr_go & addr_hit(reg_addr, `OFF_SLOT_A_INT_CTRL);
   assign we_a_path = wr_go & addr_hit(reg_addr, `OFF_SLOT_A_PATH);
   assign we_b_ctrl = wr_go & addr_hit(reg_addr, `OFF_SLOT_B_INT_CTRL);
   assign we_b_path = wr_go & addr_hit(reg_addr, `OFF_SLOT_B_PATH);
   assign we_buf_en = wr_go & addr_hit(reg_addr, `OFF_BUF_MODE_EN);

   // configuration register storage
   always_ff @(posedge clk) begin
      if (srst) begin
         input_config_reg              <= `RST_INPUT_CFG;
         slot_a_integrator_control_reg <= `RST_INT_CTRL;
         slot_a_path_connection_reg    <= `RST_PATH_WORD;
         slot_b_integrator_control_reg <= `RST_INT_CTRL;
         slot_b_path_connection_reg    <= `RST_PATH_WORD;
         buffer_mode_enable_reg        <= `RST_BUF_MODE_EN;
      end else begin
         if (we_input)  input_config_reg              <= reg_wdata;
         if (we_a_ctrl) slot_a_integrator_control_reg <= reg_wdata;
         if (we_a_path) slot_a_path_connection_reg    <= reg_wdata;
         if (we_b_ctrl) slot_b_integrator_control_reg <= reg_wdata;
         if (we_b_path) slot_b_path_connection_reg    <= reg_wdata;
         if (we_buf_en) buffer_mode_enable_reg        <= reg_wdata;
      end
   end

   // read mux; unmapped offsets read as zero
   logic [15:0] rdata_next;
   assign rdata_next =
      addr_hit(reg_addr, `OFF_INPUT_CFG)       ? input_config_reg :
      addr_hit(reg_addr, `OFF_SLOT_A_INT_CTRL) ?
         slot_a_integrator_control_reg :
      addr_hit(reg_addr, `OFF_SLOT_A_PATH)     ? slot_a_path_connection_reg :
      addr_hit(reg_addr, `OFF_SLOT_B_INT_CTRL) ?
         slot_b_integrator_control_reg :
      addr_hit(reg_addr, `OFF_SLOT_B_PATH)     ? slot_b_path_connection_reg :
      addr_hit(reg_addr, `OFF_BUF_MODE_EN)     ? buffer_mode_enable_reg :
      addr_hit(reg_addr, `OFF_SLOT_A_DATA)     ? slot_a_data_reg :
      addr_hit(reg_addr, `OFF_SLOT_B_DATA)     ? slot_b_data_reg :
      16'h0000;

   // registered read answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else if (ce) begin
         reg_rdata  <= reg_rd ? rdata_next : reg_rdata;
         reg_rvalid <= reg_rd;
      end
   end

   // per-slot field extraction and decode, one decoder per slot
   logic [15:0]             ctrl_w [2];
   logic [15:0]             path_w [2];
   logic [1:0]              led_w  [2];
   logic [3:0]              sel_w  [2];
   afe_path_pkg::path_cfg_t cfg_w  [2];

   assign ctrl_w[0] = slot_a_integrator_control_reg;
   assign ctrl_w[1] = slot_b_integrator_control_reg;
   assign path_w[0] = slot_a_path_connection_reg;
   assign path_w[1] = slot_b_path_connection_reg;
   assign led_w[0]  = input_config_reg[`LED_SEL_A_HI:`LED_SEL_A_LO];
   assign led_w[1]  = input_config_reg[`LED_SEL_B_HI:`LED_SEL_B_LO];
   assign sel_w[0]  = input_config_reg[`PD_SEL_A_HI:`PD_SEL_A_LO];
   assign sel_w[1]  = input_config_reg[`PD_SEL_B_HI:`PD_SEL_B_LO];

   genvar s;
   generate
      for (s = 0; s < 2; s++) begin : g_slot
         slot_path_decoder u_dec (
            .int_ctrl  (ctrl_w[s]),
            .path_word (path_w[s]),
            .global_en (buffer_mode_enable_reg[`BUF_GLOBAL_EN_BIT]),
            .led_sel   (led_w[s]),
            .pd_sel    (sel_w[s]),
            .cfg       (cfg_w[s])
         );
      end
   endgenerate

   // arrangement of the slot about to start
   afe_path_pkg::path_cfg_t cfg_sel;
   logic                    take_slot;
   assign cfg_sel   = slot_is_b ? cfg_w[1] : cfg_w[0];
   assign take_slot = ce & slot_start;

   // active arrangement only changes at a slot boundary
   afe_path_pkg::path_cfg_t slot_cfg_reg;
   logic                    active_b_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         slot_cfg_reg <= '0;
         active_b_reg <= 1'b0;
      end else if (take_slot) begin
         slot_cfg_reg <= cfg_sel;
         active_b_reg <= slot_is_b;
      end
   end
   assign slot_cfg    = slot_cfg_reg;
   assign active_is_b = active_b_reg;

   // photodiode connection: off when unselected, pulsed in connect mode
   logic [3:0] conn_next;
   assign conn_next =
      (slot_cfg_reg.pd_sel == 4'h0)         ? 4'h0 :
      (slot_cfg_reg.pulse_connect & ~led_pulse) ? 4'h0 :
      slot_cfg_reg.pd_sel;

   logic [3:0] pd_conn_reg;
   logic       led_en_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         pd_conn_reg <= 4'h0;
         led_en_reg  <= 1'b0;
      end else if (ce) begin
         pd_conn_reg <= conn_next;
         led_en_reg  <= ~slot_cfg_reg.pulse_connect;
      end
   end
   assign pd_connect  = pd_conn_reg;
   assign led_fire_en = led_en_reg;

   // channel sequencing in dc measurement mode
   logic seq_go;
   assign seq_go = sample_start & slot_cfg_reg.dc_mode;

   dc_channel_sequencer #(
      .CHANNELS (CHANNELS),
      .SPACING  (SPACING)
   ) u_seq (
      .clk    (clk),
      .srst   (srst),
      .ce     (ce),
      .go     (seq_go),
      .strobe (adc_strobe),
      .chan   (adc_channel)
   );

   // result: converter code less offset; zero offset passes raw code
   logic [15:0] result_w;
   assign result_w = adc_code - adc_offset;

   // result to fifo port and to the active slot's data register
   logic        fifo_valid_reg;
   logic [15:0] fifo_data_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         fifo_valid_reg  <= 1'b0;
         fifo_data_reg   <= `RST_DATA;
         slot_a_data_reg <= `RST_DATA;
         slot_b_data_reg <= `RST_DATA;
      end else if (ce) begin
         fifo_valid_reg <= adc_valid;
         if (adc_valid) begin
            fifo_data_reg <= result_w;
            if (active_b_reg) slot_b_data_reg <= result_w;
            else              slot_a_data_reg <= result_w;
         end
      end
   end
   assign fifo_valid = fifo_valid_reg;
   assign fifo_data  = fifo_data_reg;

   a_slot_latch: assert property (@(posedge clk) disable iff (srst)
      take_slot |=> slot_cfg_reg == $past(cfg_sel))
      else $error("slot arrangement not taken at slot start");

   a_cfg_hold: assert property (@(posedge clk) disable iff (srst)
      !take_slot |=> $stable(slot_cfg_reg))
      else $error("slot arrangement changed inside a measurement");

   a_pd_disconnect: assert property (@(posedge clk) disable iff (srst)
      ce && slot_cfg_reg.pd_sel == 4'h0 |=> pd_conn_reg == 4'h0)
      else $error("inputs connected with zero selection");

   a_pulse_gating: assert property (@(posedge clk) disable iff (srst)
      ce && slot_cfg_reg.pulse_connect
      |=> pd_conn_reg == ($past(led_pulse) ? $past(slot_cfg_reg.pd_sel)
                                           : 4'h0))
      else $error("pulse connect not following led timing");

   a_led_suppress: assert property (@(posedge clk) disable iff (srst)
      ce |=> led_en_reg == !$past(slot_cfg_reg.pulse_connect))
      else $error("led enable wrong for connect mode");

   a_buffer_global: assert property (@(posedge clk) disable iff (srst)
      cfg_w[0].int_buffer || cfg_w[1].int_buffer
      |-> buffer_mode_enable_reg[`BUF_GLOBAL_EN_BIT])
      else $error("buffer mode without global enable");

   a_path_decode: assert property (@(posedge clk) disable iff (srst)
      cfg_w[0].bpf_bypass == (slot_a_path_connection_reg == `PATH_BPF_BYPASS
         || slot_a_path_connection_reg == `PATH_FULL_BYPASS))
      else $error("slot a filter bypass decode wrong");

   a_full_bypass: assert property (@(posedge clk) disable iff (srst)
      cfg_w[1].int_bypass
      == (slot_b_path_connection_reg == `PATH_FULL_BYPASS))
      else $error("slot b integrator bypass decode wrong");

   a_gain_decode: assert property (@(posedge clk) disable iff (srst)
      cfg_w[1].gain_07
      == (slot_b_integrator_control_reg[`INT_GAIN_HI:`INT_GAIN_LO]
          == `GAIN_CODE_07))
      else $error("slot b buffer gain decode wrong");

   a_result_path: assert property (@(posedge clk) disable iff (srst)
      ce && adc_valid |=> fifo_valid_reg
         && fifo_data_reg == $past(adc_code) - $past(adc_offset))
      else $error("result not forwarded to fifo port");

   a_path_decode_b: assert property (@(posedge clk) disable iff (srst)
      cfg_w[1].bpf_bypass == (slot_b_path_connection_reg == `PATH_BPF_BYPASS
         || slot_b_path_connection_reg == `PATH_FULL_BYPASS))
      else $error("slot b filter bypass decode wrong");

   a_gain_decode_a: assert property (@(posedge clk) disable iff (srst)
      cfg_w[0].gain_07
      == (slot_a_integrator_control_reg[`INT_GAIN_HI:`INT_GAIN_LO]
          == `GAIN_CODE_07))
      else $error("slot a buffer gain decode wrong");

   // outside pulse connect the inputs follow the selection field
   a_pd_follow: assert property (@(posedge clk) disable iff (srst)
      ce && !slot_cfg_reg.pulse_connect
      |=> pd_conn_reg == $past(slot_cfg_reg.pd_sel))
      else $error("inputs not connected as selected");

   // a low clock enable must hold the active arrangement and outputs
   a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
      !ce |=> $stable(slot_cfg_reg) && $stable(pd_conn_reg)
         && $stable(fifo_valid_reg))
      else $error("state moved while clock enable was low");

endmodule : afe_path_mode_config
`default_nettype wire

// *** verif/analog_source_model.sv ***
// analog source model: dark-current converter results and led window
`timescale 1ns/1ps
`default_nettype none

module analog_source_model #(
   parameter int          WIN  = 100,
   parameter logic [15:0] DARK = 16'h32C8
) (
   input  wire logic        clk,
   input  wire logic        strobe,
   input  wire logic [1:0]  chan,
   input  wire logic        led_go,
   input  wire logic        slow,
   output var  logic        valid = 1'b0,
   output var  logic [15:0] code = 16'h0000,
   output var  logic        led_pulse
);
   int          wcnt = 0;
   logic        pend = 1'b0;
   logic [15:0] last = 16'h0000;

   // one result per strobe, one or two cycles late; junk in between
   always @(posedge clk) begin
      pend  <= strobe;
      valid <= 1'b0;
      code  <= ~last;
      if (slow ? pend : strobe) begin
         valid <= 1'b1;
         code  <= DARK + {14'h0000, chan};
         last  <= DARK + {14'h0000, chan};
      end
   end

   // led window of a fixed length per trigger
   always @(posedge clk) begin
      if (led_go) wcnt <= WIN;
      else if (wcnt > 0) wcnt <= wcnt - 1;
   end
   assign led_pulse = (wcnt > 0);
endmodule : analog_source_model

`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the receive-path mode configuration block
`timescale 1ns/1ps
`default_nettype none
`include "afe_path_consts.svh"

module testbench;
   localparam int          SP   = 6;
   localparam int          WIN  = 100;
   localparam logic [15:0] DARK = 16'h32C8;
   logic        clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, adc_offset = 16'h0000;
   logic        slot_start = 0, slot_is_b = 0, sample_start = 0;
   logic        led_go = 0, slow = 0, led_pulse, adc_valid, reg_rvalid;
   logic        active_is_b, led_fire_en, adc_strobe, fifo_valid;
   logic [15:0] reg_rdata, adc_code, fifo_data, r;
   logic [3:0]  pd_connect;
   logic [1:0]  adc_channel;
   afe_path_pkg::path_cfg_t slot_cfg, e;
   logic [15:0] s14 = 16'h0555, s58 = 16'h0000;
   logic [15:0] sctl[2] = '{16'h1C00, 16'h1C00};
   logic [15:0] sw[2] = '{16'hADA5, 16'hADA5};
   logic [15:0] words[3] = '{16'hADA5, 16'hAE65, 16'hB065};
   logic [7:0]  ra[9] = '{8'h14, 8'h42, 8'h43, 8'h44, 8'h45, 8'h58,
                          8'h70, 8'h71, 8'h30};
   logic [15:0] rv[9] = '{16'h0555, 16'h1C00, 16'hADA5, 16'h1C00,
                          16'hADA5, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [31:0] lfsr = 32'h0001_3126; // starts at 78118
   int          failures = 0, n_checks = 0, t, ns, nf;

   // clock
   always #10 clk = ~clk;

   afe_path_mode_config #(.CHANNELS(4), .SPACING(SP)) i_afe_path_mode_config (
      .clk, .srst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .slot_start, .slot_is_b, .sample_start, .led_pulse,
      .adc_valid, .adc_code, .adc_offset, .slot_cfg, .active_is_b,
      .pd_connect, .led_fire_en, .adc_strobe, .adc_channel, .fifo_valid,
      .fifo_data);

   analog_source_model #(.WIN(WIN), .DARK(DARK)) i_analog_source_model (
      .clk, .strobe(adc_strobe), .chan(adc_channel), .led_go, .slow,
      .valid(adc_valid), .code(adc_code), .led_pulse);

   // stimulus source and expected slot arrangement
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
      return lfsr[31:16];
   endfunction : rnd

   function automatic afe_path_pkg::path_cfg_t exp_cfg(
      input logic [15:0] c, input logic [15:0] w, input logic g,
      input logic [1:0] led, input logic [3:0] pd);
      afe_path_pkg::path_cfg_t x;
      x.int_bypass    = (w == `PATH_FULL_BYPASS);
      x.bpf_bypass    = x.int_bypass || (w == `PATH_BPF_BYPASS);
      x.dc_mode       = x.bpf_bypass;
      x.int_buffer    = c[7] && g && !x.int_bypass;
      x.gain_07       = (c[9:8] == 2'h2);
      x.pulse_connect = (led == 2'h0);
      x.int_setup     = c[15:10];
      x.pd_sel        = pd;
      return x;
   endfunction : exp_cfg

   // comparison, verdict and bus cycles
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1;
      step();
      reg_wr    = 0;
      // idle edge so a following request never re-raises the strobe at once
      step();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      reg_addr = a;
      reg_rd   = 1;
      step();
      reg_rd   = 0;
      cmp(16'(reg_rvalid), 16'h0001);
      cmp(reg_rdata, exp);
      step();
   endtask : rd

   // start one slot measurement and check its decoded arrangement
   task automatic slot(input logic b);
      e = exp_cfg(sctl[b], sw[b], s58[7], b ? s14[3:2] : s14[1:0],
                  b ? s14[11:8] : s14[7:4]);
      slot_is_b  = b;
      slot_start = 1;
      step();
      slot_start = 0;
      cmp(16'(slot_cfg), 16'(e));
      cmp(16'(active_is_b), 16'(b));
      step();
      cmp(16'(pd_connect), e.pulse_connect ? 16'h0 : 16'(e.pd_sel));
      cmp(16'(led_fire_en), 16'(!e.pulse_connect));
   endtask : slot

   // dc sequence on one slot, with a refused restart in mid-run
   task automatic dc_run(input logic b);
      sw[b] = `PATH_BPF_BYPASS;
      wr(b ? 8'h45 : 8'h43, sw[b]);
      slot(b);
      slow = b;
      r = rnd();
      adc_offset = {8'h00, r[7:0]};
      sample_start = 1;
      ns = 0;
      nf = 0;
      for (t = 1; t < 40; t++) begin
         step();
         sample_start = (t == 3);
         if (adc_strobe === 1'b1) begin
            cmp(16'(adc_channel), 16'(ns));
            cmp(16'(t), 16'(1 + SP * ns));
            ns++;
         end
         if (fifo_valid === 1'b1) begin
            cmp(fifo_data, DARK + 16'(nf) - adc_offset);
            nf++;
         end
      end
      cmp(16'(ns), 16'h0004);
      cmp(16'(nf), 16'h0004);
      rd(b ? 8'h71 : 8'h70, DARK + 16'h0003 - adc_offset);
   endtask : dc_run

   // watchdog against a hang
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      results();
   end

   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      #1;
      srst = 0;
      foreach (ra[i]) rd(ra[i], rv[i]);
      wr(8'h30, 16'hFFFF);
      wr(8'h70, 16'hFFFF);
      ce = 0;
      wr(8'h58, 16'hFFFF);
      ce = 1;
      rd(8'h30, 16'h0000);
      rd(8'h70, 16'h0000);
      rd(8'h58, 16'h0000);
      $display("test registers done");
      for (int i = 0; i < 24; i++) begin
         for (int b = 0; b < 2; b++) begin
            r = rnd();
            sw[b] = (r[1:0] == 2'h3) ? rnd() : words[r[1:0]];
            sctl[b] = rnd();
            if (sw[b] == `PATH_NORMAL) sctl[b][15:10] = 6'h07;
            else sctl[b][5:4] = 2'h2;
            wr(b ? 8'h44 : 8'h42, sctl[b]);
            wr(b ? 8'h45 : 8'h43, sw[b]);
         end
         s58 = rnd();
         s14 = (i == 0) ? 16'h0003 : rnd();
         wr(8'h58, s58);
         wr(8'h14, s14);
         for (int b = 0; b < 2; b++) begin
            rd(b ? 8'h44 : 8'h42, sctl[b]);
            rd(b ? 8'h45 : 8'h43, sw[b]);
         end
         rd(8'h58, s58);
         for (int b = 0; b < 2; b++) begin
            slot(b[0]);
            sw[b] = ~sw[b];
            wr(b ? 8'h45 : 8'h43, sw[b]);
            cmp(16'(slot_cfg), 16'(e));
         end
      end
      $display("test slot decode done");
      s14 = 16'h0F50;
      wr(8'h14, s14);
      slot(1'b0);
      led_go = 1;
      step();
      led_go = 0;
      t = 0;
      repeat (200) begin
         step();
         if (pd_connect === 4'h5) t++;
      end
      cmp(16'(t), 16'(WIN));
      $display("test pulse connect done");
      dc_run(1'b0);
      dc_run(1'b1);
      $display("test dc sequence done");
      results();
   end
endmodule : testbench

`default_nettype wire
